/* File: hdl/srd_link_mem.sv */
// small memory of per-link direction and network fields, registered read
`timescale 1ns/1ns
module srd_link_mem
  import srd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_idx,
  input  wire srd_link_cfg_type wr_data,
  input  wire logic [3:0]       rd_idx,
  output srd_link_cfg_type      rd_data
);

  // all state: storage plus registered read word
  typedef struct packed {
    srd_link_cfg_type [15:0] mem;
    srd_link_cfg_type        rd;
  } srd_mem_state_type;

  srd_mem_state_type s_q;  // registered state
  srd_mem_state_type s_d;  // next state

  // write one entry, read one entry into the output register
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_idx] = wr_data;
    end
    s_d.rd = s_q.mem[rd_idx];
  end

  // fields reset to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;

endmodule

/* File: hdl/srd_regs.sv */
// node configuration registers for routing directions, debug line and link status
`timescale 1ns/1ns
module srd_regs
  import srd_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h0001,  // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h001,   // arbitrary value
  parameter logic [17:0] METAL_ID   = 18'h00001  // arbitrary value
)(
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire srd_cfg_req_type              cfg_req,
  output srd_cfg_rsp_type                   cfg_rsp,
  input  wire logic [13:0]                  otp_user_code,
  input  wire srd_link_stat_type [2*NUM_LINKS-1:0] link_stat,
  input  wire logic [15:0]                  node_id,
  input  wire logic                         route_req,
  input  wire logic [15:0]                  route_dest_id,
  output logic                              route_valid,
  output logic                              route_local,
  output logic [3:0]                        route_dir,
  output logic [15:0]                       ref_div,
  input  wire logic [1:0]                   core_halted_flag,
  output logic [1:0]                        core_debug_req,
  input  wire logic                         shared_debug_line_n_i,
  output logic                              shared_debug_line_n_o,
  output logic                              shared_debug_line_n_oe
);

  // all state of this block except the reset synchroniser
  typedef struct packed {
    srd_cfg_state_type st;       // answer sequencer
    logic              wr;       // taken access was a write
    logic [7:0]        addr;     // taken register number
    logic [15:0]       ref_div;  // reference clock divider
    logic [31:0]       dir_lo;   // directions of dimensions 0..7
    logic [31:0]       dir_hi;   // directions of dimensions 8..15
    logic [1:0]        dbg_t0;   // tile 0 coupling
    logic [1:0]        dbg_t1;   // tile 1 coupling
    logic              src_pin;  // last event came from the pin
    logic [1:0]        src_core; // last event came from a core
    logic              pin_s1;   // pin synchroniser, first stage
    logic              pin_s2;   // pin synchroniser, second stage
    logic              line_q;   // shared line seen last cycle
    logic [1:0]        dbg_req;  // debug requests to the cores
    logic              line_oe;  // pulling the shared pin low
    logic              line_o;   // level driven, always low
    logic              ready;    // may take a request
    logic              ack;      // answer pulse
    logic              err;      // unmapped register number
    logic [31:0]       rdata;    // read answer
  } srd_state_type;

  srd_state_type    s_q;        // registered state
  srd_state_type    s_d;        // next state
  logic [1:0]       rst_sync_q; // reset release synchroniser
  logic             rst_n;      // synchronised reset
  srd_link_cfg_type mem_rd;     // per-link fields of the addressed link
  logic             mem_wr;     // write strobe into the link memory
  logic [3:0]       mem_wr_idx; // link entry being written
  srd_link_cfg_type mem_wr_dat; // merged write fields
  logic [3:0]       mem_rd_idx; // link entry being read
  logic             take;       // request accepted this cycle

  // true when the number falls in an eight-register link range
  function automatic logic in_links(input logic [7:0] a, input logic [7:0] base);
    return (a[7:3] == base[7:3]);
  endfunction

  // reset is released through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // accept a request only while idle
  assign take = cfg_req.req & s_q.ready;

  // link memory port control: serial links 0..7, processor links 8..15
  always_comb begin
    mem_wr     = 1'b0;
    mem_wr_idx = 4'h0;
    mem_wr_dat = '0;
    mem_rd_idx = {cfg_req.addr[6], cfg_req.addr[2:0]};
    if (take && cfg_req.wr) begin
      if (in_links(cfg_req.addr, OFF_SWITCH_SERIAL_LINK_BASE)) begin
        mem_wr         = 1'b1;
        mem_wr_idx     = {1'b0, cfg_req.addr[2:0]};
        mem_wr_dat.dir = cfg_req.wdata[LS_DIR_LSB +: 4];
        mem_wr_dat.net = cfg_req.wdata[LS_NET_LSB +: 2];
      end else if (in_links(cfg_req.addr, OFF_PROCESSOR_SIDE_LINK_BASE)) begin
        mem_wr         = 1'b1;
        mem_wr_idx     = {1'b1, cfg_req.addr[2:0]};
        mem_wr_dat.dir = 4'h0; // no direction on processor links
        mem_wr_dat.net = cfg_req.wdata[LS_NET_LSB +: 2];
      end
    end
  end

  // per-link direction and network storage
  srd_link_mem u_link_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (mem_wr),
    .wr_idx  (mem_wr_idx),
    .wr_data (mem_wr_dat),
    .rd_idx  (mem_rd_idx),
    .rd_data (mem_rd)
  );

  // direction lookup for packets leaving this node
  srd_route_pick u_route (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .req_valid (route_req),
    .node_id   (node_id),
    .dest_id   (route_dest_id),
    .dirs      ({s_q.dir_hi, s_q.dir_lo}),
    .dir_valid (route_valid),
    .dir_local (route_local),
    .dir_out   (route_dir)
  );

  // next-state logic: register writes, debug line, read answers
  always_comb begin
    logic [1:0]        drive;    // cores pulling the shared line
    logic              pin_low;  // pin seen low after sync
    logic              line;     // shared line active
    logic [31:0]       rd;       // read word being built
    logic              hit;      // number is mapped
    srd_link_stat_type ls;       // status of the addressed link
    drive   = 2'b00;
    pin_low = 1'b0;
    line    = 1'b0;
    rd      = 32'h0000_0000;
    hit     = 1'b0;
    ls      = '0;
    s_d     = s_q;

    // pin synchroniser, second stage is the only reader of the first
    s_d.pin_s1 = shared_debug_line_n_i;
    s_d.pin_s2 = s_q.pin_s1;

    // register writes; read-only and reserved bits are dropped
    if (take && cfg_req.wr) begin
      case (cfg_req.addr)
        OFF_REF_DIV: begin
          s_d.ref_div = cfg_req.wdata[REF_DIV_W-1:0];
        end
        OFF_DIR_LO: begin
          s_d.dir_lo = cfg_req.wdata;
        end
        OFF_DIR_HI: begin
          s_d.dir_hi = cfg_req.wdata;
        end
        OFF_DBG_TILE0: begin
          s_d.dbg_t0 = cfg_req.wdata[1:0];
        end
        OFF_DBG_TILE1: begin
          s_d.dbg_t1 = cfg_req.wdata[1:0];
        end
        OFF_DBG_SRC: begin
          s_d.src_pin  = cfg_req.wdata[SRC_PIN_BIT];
          s_d.src_core = {cfg_req.wdata[SRC_CORE1_BIT], cfg_req.wdata[SRC_CORE0_BIT]};
        end
        default: begin
          // identifier, user code and unmapped numbers ignore writes
        end
      endcase
    end

    // shared debug line: cores drive it when enabled, pin feeds it too
    drive[0] = s_q.dbg_t0[DBG_EN_DRV_BIT] & core_halted_flag[0];
    drive[1] = s_q.dbg_t1[DBG_EN_DRV_BIT] & core_halted_flag[1];
    pin_low  = ~s_q.pin_s2;
    line     = (|drive) | pin_low;
    s_d.line_q  = line;
    s_d.line_oe = |drive;
    s_d.line_o  = 1'b0;

    // requests to the cores follow the line when enabled
    s_d.dbg_req[0] = line & s_q.dbg_t0[DBG_EN_REQ_BIT];
    s_d.dbg_req[1] = line & s_q.dbg_t1[DBG_EN_REQ_BIT];

    // new event records its origin; beats a same-cycle software write
    if (line && !s_q.line_q) begin
      s_d.src_core = drive;
      s_d.src_pin  = pin_low & ~(|drive);
    end

    // answer sequencer
    s_d.ack = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (take) begin
          s_d.st    = ST_ANSWER;
          s_d.wr    = cfg_req.wr;
          s_d.addr  = cfg_req.addr;
          s_d.ready = 1'b0;
        end
      end
      ST_ANSWER: begin
        ls = link_stat[{s_q.addr[6], s_q.addr[2:0]}];
        case (s_q.addr)
          OFF_REF_DIV: begin
            hit = 1'b1;
            rd  = {16'h0000, s_q.ref_div};
          end
          OFF_JTAG_ID: begin
            hit = 1'b1;
            rd  = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
          end
          OFF_USER_CODE: begin
            hit = 1'b1;
            rd  = {otp_user_code, METAL_ID};
          end
          OFF_DIR_LO: begin
            hit = 1'b1;
            rd  = s_q.dir_lo;
          end
          OFF_DIR_HI: begin
            hit = 1'b1;
            rd  = s_q.dir_hi;
          end
          OFF_DBG_TILE0: begin
            hit = 1'b1;
            rd  = {30'h0000_0000, s_q.dbg_t0};
          end
          OFF_DBG_TILE1: begin
            hit = 1'b1;
            rd  = {30'h0000_0000, s_q.dbg_t1};
          end
          OFF_DBG_SRC: begin
            hit = 1'b1;
            rd[SRC_PIN_BIT]   = s_q.src_pin;
            rd[SRC_CORE1_BIT] = s_q.src_core[1];
            rd[SRC_CORE0_BIT] = s_q.src_core[0];
          end
          default: begin
            // link status ranges, reserved bits stay zero
            if (in_links(s_q.addr, OFF_SWITCH_SERIAL_LINK_BASE) ||
                in_links(s_q.addr, OFF_PROCESSOR_SIDE_LINK_BASE)) begin
              hit = 1'b1;
              rd[LS_KIND_LSB +: 2]  = ls.link_target_kind;
              rd[LS_DEST_LSB +: 8]  = ls.dest_link;
              rd[LS_NET_LSB +: 2]   = mem_rd.net;
              rd[LS_JUNK_BIT]       = ls.junk;
              rd[LS_DST_USE_BIT]    = ls.dst_use;
              rd[LS_SRC_USE_BIT]    = ls.src_use;
              if (!s_q.addr[6]) begin
                rd[LS_DIR_LSB +: 4] = mem_rd.dir;
              end
            end
          end
        endcase
        s_d.st    = ST_IDLE;
        s_d.ack   = 1'b1;
        s_d.err   = ~hit;
        s_d.rdata = s_q.wr ? 32'h0000_0000 : rd;
        s_d.ready = 1'b1;
      end
      default: begin
        s_d.st    = ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // state register; reset values from the package
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.ref_div  <= REF_DIV_RST;
      s_q.dir_lo   <= DIR_RST;
      s_q.dir_hi   <= DIR_RST;
      s_q.dbg_t0   <= DBG_CFG_RST;
      s_q.dbg_t1   <= DBG_CFG_RST;
      s_q.pin_s1   <= 1'b1;
      s_q.pin_s2   <= 1'b1;
      s_q.ready    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign cfg_rsp.ready          = s_q.ready;
  assign cfg_rsp.ack            = s_q.ack;
  assign cfg_rsp.err            = s_q.err;
  assign cfg_rsp.rdata          = s_q.rdata;
  assign ref_div                = s_q.ref_div;
  assign core_debug_req         = s_q.dbg_req;
  assign shared_debug_line_n_o  = s_q.line_o;
  assign shared_debug_line_n_oe = s_q.line_oe;

endmodule

/* File: hdl/srd_route_pick.sv */
// chooses the output direction from the highest mismatching node identifier bit
`timescale 1ns/1ns
module srd_route_pick
  import srd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  input  wire logic [15:0] node_id,
  input  wire logic [15:0] dest_id,
  input  wire logic [63:0] dirs,
  output logic             dir_valid,
  output logic             dir_local,
  output logic [3:0]       dir_out
);

  // state: one registered answer
  typedef struct packed {
    logic       valid;
    logic       local_hit;
    logic [3:0] dir;
  } srd_route_state_type;

  srd_route_state_type s_q;  // registered answer
  srd_route_state_type s_d;  // next answer

  // index of the highest set bit, zero when none
  function automatic logic [3:0] msb_index(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // dimension is the top mismatching bit; its nibble names the direction
  always_comb begin
    logic [15:0] diff;
    logic [3:0]  dim;
    diff        = node_id ^ dest_id;
    dim         = msb_index(diff);
    s_d         = s_q;
    s_d.valid   = req_valid;
    s_d.local_hit = (diff == 16'h0000);
    s_d.dir     = dirs[{dim, 2'b00} +: 4];
  end

  // answer register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dir_valid = s_q.valid;
  assign dir_local = s_q.local_hit;
  assign dir_out   = s_q.dir;

endmodule

/* File: shared/srd_pkg.sv */
// shared constants and carrier types for the switch routing and debug register block
package srd_pkg;

  // register numbers on the node configuration port
  localparam logic [7:0] OFF_REF_DIV    = 8'h08;
  localparam logic [7:0] OFF_JTAG_ID    = 8'h09;
  localparam logic [7:0] OFF_USER_CODE  = 8'h0a;
  localparam logic [7:0] OFF_DIR_LO     = 8'h0c;
  localparam logic [7:0] OFF_DIR_HI     = 8'h0d;
  localparam logic [7:0] OFF_DBG_TILE0  = 8'h10;
  localparam logic [7:0] OFF_DBG_TILE1  = 8'h11;
  localparam logic [7:0] OFF_DBG_SRC    = 8'h1f;
  localparam logic [7:0] OFF_SWITCH_SERIAL_LINK_BASE = 8'h20;
  localparam logic [7:0] OFF_PROCESSOR_SIDE_LINK_BASE = 8'h40;
  localparam int         NUM_LINKS      = 8;

  // values after reset
  localparam logic [15:0] REF_DIV_RST = 16'h0003;
  localparam logic [31:0] DIR_RST     = 32'h0000_0000;
  localparam logic [1:0]  DBG_CFG_RST = 2'h0;

  // field positions
  localparam int REF_DIV_W       = 16;
  localparam int JTAG_VER_LSB    = 28;
  localparam int JTAG_PART_LSB   = 12;
  localparam int JTAG_MAKER_LSB  = 1;
  localparam int USER_OTP_LSB    = 18;
  localparam int DBG_EN_REQ_BIT  = 1;
  localparam int DBG_EN_DRV_BIT  = 0;
  localparam int SRC_PIN_BIT     = 4;
  localparam int SRC_CORE1_BIT   = 1;
  localparam int SRC_CORE0_BIT   = 0;
  localparam int LS_KIND_LSB     = 24;
  localparam int LS_DEST_LSB     = 16;
  localparam int LS_DIR_LSB      = 8;
  localparam int LS_NET_LSB      = 4;
  localparam int LS_JUNK_BIT     = 2;
  localparam int LS_DST_USE_BIT  = 1;
  localparam int LS_SRC_USE_BIT  = 0;

  // live status of one link, from the switch fabric
  typedef struct packed {
    logic [1:0] link_target_kind;  // 0 serial, 1 processor, 2 control endpoint
    logic [7:0] dest_link;         // destination link while in use
    logic       junk;              // current packet being discarded
    logic       dst_use;           // destination side busy
    logic       src_use;           // source side busy
  } srd_link_stat_type;

  // software fields stored per link
  typedef struct packed {
    logic [3:0] dir;
    logic [1:0] net;
  } srd_link_cfg_type;

  // configuration request from the node configuration path
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } srd_cfg_req_type;

  // configuration answer
  typedef struct packed {
    logic        ready;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } srd_cfg_rsp_type;

  // answer sequencer states
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ANSWER = 1'b1
  } srd_cfg_state_type;

endpackage

/* File: sim/srd_regs_asserts.sv */
// port-level concurrent checks for the routing and debug register block
`timescale 1ns/1ns
module srd_regs_asserts
  import srd_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            rstn,
  input wire srd_cfg_req_type cfg_req,
  input wire srd_cfg_rsp_type cfg_rsp,
  input wire logic [15:0]     node_id,
  input wire logic            route_req,
  input wire logic [15:0]     route_dest_id,
  input wire logic            route_valid,
  input wire logic            route_local,
  input wire logic [15:0]     ref_div,
  input wire logic [1:0]      core_halted_flag,
  input wire logic [1:0]      core_debug_req,
  input wire logic            shared_debug_line_n_i,
  input wire logic            shared_debug_line_n_o,
  input wire logic            shared_debug_line_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic take;     // request accepted at this edge
  logic div_wr;   // accepted write to the divider
  logic any_halt; // some core halted
  assign take     = cfg_req.req && cfg_rsp.ready;
  assign div_wr   = take && cfg_req.wr && (cfg_req.addr == OFF_REF_DIV);
  assign any_halt = |core_halted_flag;

  a_answer_timing: assert property (take |=> !cfg_rsp.ready && !cfg_rsp.ack ##1
    cfg_rsp.ack && cfg_rsp.ready) else $error("answer not on second edge");
  a_div_write: assert property (div_wr |=> ref_div == $past(cfg_req.wdata[15:0]))
    else $error("divider not written");
  a_div_hold: assert property (!$stable(ref_div) |-> $past(div_wr))
    else $error("divider changed without write");
  a_unmapped_err: assert property (take && cfg_req.addr == 8'h0b |=> ##1
    cfg_rsp.ack && cfg_rsp.err) else $error("unmapped number not flagged");
  a_mapped_ok: assert property (take && cfg_req.addr == OFF_REF_DIV |=> ##1 !cfg_rsp.err)
    else $error("mapped number flagged");
  a_idcode_one: assert property (take && !cfg_req.wr && cfg_req.addr == OFF_JTAG_ID
    |=> ##1 cfg_rsp.rdata[0]) else $error("identifier bit zero low");
  a_route_answer: assert property (route_req |=> route_valid)
    else $error("route answer missing");
  a_route_local: assert property (route_req |=>
    route_local == ($past(route_dest_id) == $past(node_id))) else $error("local flag wrong");
  a_drive_low: assert property (shared_debug_line_n_oe |-> !shared_debug_line_n_o)
    else $error("line driven high");
  a_drive_cause: assert property (shared_debug_line_n_oe |-> $past(any_halt))
    else $error("line driven with no halted core");
  a_request_cause: assert property (|core_debug_req |-> $past(any_halt)
    || !$past(shared_debug_line_n_i, 2) || !$past(shared_debug_line_n_i, 3))
    else $error("debug request without line event");

  c_write: cover property (take && cfg_req.wr);
  c_route_far: cover property (route_valid && !route_local);
  c_debug_req: cover property (|core_debug_req);
endmodule

/* File: sim/srd_regs_tb_top.sv */
// self-checking bench for the routing and debug register block
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module srd_regs_tb_top;
  import srd_pkg::*;
  localparam logic [3:0]  VER   = 4'h6;     // arbitrary value
  localparam logic [15:0] PART  = 16'h1234; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2a5;  // arbitrary value
  localparam logic [17:0] METAL = 18'h2b3c4; // arbitrary value
  logic                                clk_sys = 1'b0;
  logic                                rstn = 1'b0;
  srd_cfg_req_type                     cfg_req = '0;
  srd_cfg_rsp_type                     cfg_rsp;
  logic [13:0]                         otp = 14'h2d1e;
  srd_link_stat_type [2*NUM_LINKS-1:0] link_stat;
  logic [15:0]                         node_id = 16'ha5c3;
  logic                                route_req = 1'b0;
  logic [15:0]                         route_dest_id = 16'h0;
  logic                                route_valid;
  logic                                route_local;
  logic [3:0]                          route_dir;
  logic [15:0]                         ref_div;
  logic [1:0]                          halted = 2'h0;
  logic [1:0]                          core_debug_req;
  logic                                ext_n = 1'b1; // outside party, pulled up
  logic                                pin_n;
  logic                                line_o;
  logic                                line_oe;
  int                                  err_count = 0;
  int                                  checks = 0;
  logic [31:0]                         rd;
  logic                                rerr;

  assign pin_n = line_oe ? line_o : ext_n; // wired debug line
  always #2 clk_sys = ~clk_sys;

  srd_regs #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .METAL_ID(METAL)) u_srd_regs (
    .clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .otp_user_code(otp), .link_stat(link_stat), .node_id(node_id), .route_req(route_req),
    .route_dest_id(route_dest_id), .route_valid(route_valid), .route_local(route_local),
    .route_dir(route_dir), .ref_div(ref_div), .core_halted_flag(halted),
    .core_debug_req(core_debug_req), .shared_debug_line_n_i(pin_n),
    .shared_debug_line_n_o(line_o), .shared_debug_line_n_oe(line_oe));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // a wait that used up its bound counts a mismatch and ends the run
  task automatic stall(input string what);
    err_count++;
    $display("unexpected at %0t: %s", $time, what);
    conclude();
  endtask

  // one node configuration access, held until taken, then wait for the answer
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    for (i = 0; i < 20 && cfg_rsp.ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 20) stall("port never ready");
    cfg_req <= '{req: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    cfg_req.req <= 1'b0;
    for (i = 0; i < 20 && cfg_rsp.ack !== 1'b1; i++) @(negedge clk_sys);
    if (i == 20) stall("no answer");
    rd = cfg_rsp.rdata;
    rerr = cfg_rsp.err;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(rd, e);
    `CHK(rerr, 1'b0);
  endtask

  // expected link word from the status driven here
  function automatic logic [31:0] lw(input int i, input logic [3:0] d, input logic [1:0] n);
    return {6'h0, link_stat[i][12:3], 4'h0, d, 2'h0, n, 1'b0, link_stat[i][2:0]};
  endfunction

  task automatic set_links(input logic [2:0] flip);
    for (int i = 0; i < 16; i++) link_stat[i] = {2'(i), 8'h30 + 8'(i), 3'(i) ^ flip};
  endtask

  task automatic t_regs;
    rchk(OFF_REF_DIV, 32'h3);
    rchk(OFF_DIR_LO, 32'h0);
    rchk(OFF_DIR_HI, 32'h0);
    rchk(OFF_DBG_TILE1, 32'h0);
    rchk(OFF_SWITCH_SERIAL_LINK_BASE, lw(0, 4'h0, 2'h0));
    acc(1'b1, OFF_REF_DIV, 32'hffff_abcd);
    rchk(OFF_REF_DIV, 32'h0000_abcd);
    `CHK(ref_div, 16'habcd);
    acc(1'b1, OFF_JTAG_ID, 32'h0);
    acc(1'b1, OFF_USER_CODE, 32'h0);
    rchk(OFF_JTAG_ID, {VER, PART, MAKER, 1'b1});
    rchk(OFF_USER_CODE, {otp, METAL});
    acc(1'b0, 8'h0b, 32'h0);
    `CHK(rerr, 1'b1);
    acc(1'b0, 8'h28, 32'h0);
    `CHK(rerr, 1'b1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(4);
    rchk(OFF_REF_DIV, 32'h3);
    $display("test registers done");
  endtask

  task automatic t_route;
    acc(1'b1, OFF_DIR_LO, 32'h89ab_cdef);
    acc(1'b1, OFF_DIR_HI, 32'h0123_4567);
    rchk(OFF_DIR_HI, 32'h0123_4567);
    route_req <= 1'b1;
    for (int d = 0; d < 17; d++) begin
      route_dest_id <= (d == 16) ? node_id : node_id ^ 16'((32'h1 << (d + 1)) - 1);
      @(negedge clk_sys);
      `CHK(route_valid, 1'b1);
      `CHK(route_local, (d == 16));
      `CHK(route_dir, (d == 16) ? 4'hf : 4'(15 - d));
    end
    route_req <= 1'b0;
    $display("test routing done");
  endtask

  task automatic t_debug;
    acc(1'b1, OFF_DBG_TILE0, 32'hffff_ffff);
    rchk(OFF_DBG_TILE0, 32'h3);
    acc(1'b1, OFF_DBG_TILE1, 32'h2);
    halted <= 2'b10;
    cyc(6);
    `CHK(line_oe, 1'b0);
    `CHK(core_debug_req, 2'b00);
    halted <= 2'b01;
    cyc(6);
    `CHK(line_oe, 1'b1);
    `CHK(core_debug_req, 2'b11);
    rchk(OFF_DBG_SRC, 32'h1);
    halted <= 2'b00;
    cyc(6);
    `CHK(core_debug_req, 2'b00);
    ext_n <= 1'b0;
    cyc(6);
    `CHK(core_debug_req, 2'b11);
    rchk(OFF_DBG_SRC, 32'h10);
    ext_n <= 1'b1;
    acc(1'b1, OFF_DBG_TILE1, 32'h1);
    cyc(3);
    halted <= 2'b10;
    cyc(6);
    `CHK(core_debug_req, 2'b01);
    rchk(OFF_DBG_SRC, 32'h2);
    acc(1'b1, OFF_DBG_SRC, 32'hffff_ffff);
    rchk(OFF_DBG_SRC, 32'h13);
    halted <= 2'b00;
    $display("test debug line done");
  endtask

  task automatic t_links;
    logic [7:0] a;
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? OFF_SWITCH_SERIAL_LINK_BASE + 8'(i) : OFF_PROCESSOR_SIDE_LINK_BASE + 8'(i - 8);
      acc(1'b1, a, {20'hfffff, 4'(i), 2'b11, 2'(i), 4'hf});
      rchk(a, lw(i, (i < 8) ? 4'(i) : 4'h0, 2'(i)));
      set_links(3'b111);
      rchk(a, lw(i, (i < 8) ? 4'(i) : 4'h0, 2'(i)));
      set_links(3'b000);
    end
    $display("test link status done");
  endtask

  initial begin
    set_links(3'b000);
    cyc(5);
    rstn <= 1'b1;
    cyc(4);
    t_regs();
    t_route();
    t_debug();
    t_links();
    conclude();
  end
endmodule

bind srd_regs srd_regs_asserts u_srd_regs_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .node_id(node_id),
  .route_req(route_req), .route_dest_id(route_dest_id), .route_valid(route_valid),
  .route_local(route_local), .ref_div(ref_div), .core_halted_flag(core_halted_flag),
  .core_debug_req(core_debug_req), .shared_debug_line_n_i(shared_debug_line_n_i),
  .shared_debug_line_n_o(shared_debug_line_n_o),
  .shared_debug_line_n_oe(shared_debug_line_n_oe));
